// [hdl/dfs_map.vh]
`ifndef DFS_MAP_VH
`define DFS_MAP_VH
// Measurement and limit width
`define DFS_MEAS_W        16
// Timer width for temperature qualification
`define DFS_TMR_W         16
// Error vector bit positions
`define DFS_ERR_W         13
`define DFS_E_LOGIC_UV    0
`define DFS_E_OVERCUR     1
`define DFS_E_CSQT        2
`define DFS_E_FOLLOW      3
`define DFS_E_PARMEM      4
`define DFS_E_BUS         5
`define DFS_E_PROC        6
`define DFS_E_PS_OV       7
`define DFS_E_PS_UV       8
`define DFS_E_DRV_OT      9
`define DFS_E_MOT_OT      10
`define DFS_E_SHORT       11
`define DFS_E_SENSOR      12
// Drive state encodings (one-hot)
`define DFS_ST_W          4
`define DFS_ST_SOD        4'h1
`define DFS_ST_RUN        4'h2
`define DFS_ST_FRA        4'h4
`define DFS_ST_FAULT      4'h8
// Short circuit detection floor, volts, in measurement LSB of 0.1 V
`define DFS_SC_MIN_V      10
`define DFS_SC_MIN_CODE   16'h0064
// Encoder defaults
`define DFS_ENC_PPR       2048
`define DFS_ENC_MAX_KHZ   700
`define DFS_CLK_KHZ       10000
// Minimum encoder edge spacing, in cycles (rounded down, at least one)
`define DFS_ENC_MIN_CYC   (`DFS_CLK_KHZ / (`DFS_ENC_MAX_KHZ * 4) > 0 ? `DFS_CLK_KHZ / (`DFS_ENC_MAX_KHZ * 4) : 1)
`endif

// [hdl/dfs_supervisor.v]
// Contract
// [R1] Logic supply below minimum raises undervoltage error.
// [R2] Output current above limit raises overcurrent error.
// [R3] RMS current above programmed limit raises current-squared-time error.
// [R4] Following error above limit raises error unless masked.
// [R5] Failed parameter memory read or write raises error.
// [R6] Fieldbus communication failure raises error.
// [R7] Procedure start or end failure, incl. homing timeout, raises error.
// [R8] Power stage voltage above upper limit raises overvoltage error.
// [R9] Power stage absent or below lower limit raises undervoltage error.
// [R10] Drive and motor temperature over their limits raise separate errors.
// [R11] Temperature errors raise only after condition outlasts programmed time.
// [R12] Any active error passes fault reaction active, then fault. Code: only unmasked errors do, from switch on disabled or run.
// [R13] Errors stay latched until reset and are readable.
// [R14] Error reset clears a latch only when its cause is gone.
// [R15] Successful reset moves fault to switch on disabled.
// [R16] Controller removes cause, resets, then checks ready.
// [R17] Masked following error lets the move continue.
// [R18] Masked power undervoltage is only a warning; drive stays ready.
// [R19] Short circuit not detected below 10 V power stage voltage.
// [R20] Encoder default 2048 ppr, software set; up to 700 kHz.
// [R21] Commutation tracks are spaced 120 electrical degrees.
// [R22] Brake on releases, off holds; overload disables switch.
// [R23] Mask bits, timer enables; reset clears latches and timers.
// [R24] Combined fault on unmasked latched error; masked undervoltage is warning.
`timescale 1ns/1ps
`default_nettype none
`include "dfs_map.vh"
module dfs_supervisor #(
    parameter MW  = `DFS_MEAS_W,
    parameter TW  = `DFS_TMR_W,
    parameter PPR = `DFS_ENC_PPR
) (
    // Clock and reset
    input  wire          i_clk,
    input  wire          i_rst,

    // Measurements from the sense chain
    input  wire [MW-1:0] i_logic_v,
    input  wire [MW-1:0] i_out_cur,
    input  wire [MW-1:0] i_rms_cur,
    input  wire [MW-1:0] i_follow_err,
    input  wire [MW-1:0] i_ps_v,
    input  wire [MW-1:0] i_drv_temp,
    input  wire [MW-1:0] i_mot_temp,

    // Programmed limits
    input  wire [MW-1:0] i_logic_v_min,
    input  wire [MW-1:0] i_cur_max,
    input  wire [MW-1:0] i_csqt_max,
    input  wire [MW-1:0] i_follow_max,
    input  wire [MW-1:0] i_ps_v_max,
    input  wire [MW-1:0] i_ps_v_min,
    input  wire [MW-1:0] i_drv_temp_max,
    input  wire [MW-1:0] i_mot_temp_max,
    input  wire [TW-1:0] i_drv_temp_time,
    input  wire [TW-1:0] i_mot_temp_time,

    // Masks and timer enables
    input  wire          i_mask_follow,
    input  wire          i_mask_ps_uv,
    input  wire          i_tmr_en_drv,
    input  wire          i_tmr_en_mot,

    // Event strobes from firmware side logic
    input  wire          i_parmem_fail,
    input  wire          i_bus_fail,
    input  wire          i_proc_fail,
    input  wire          i_short_det,

    // Control requests
    input  wire          i_err_reset,
    input  wire          i_enable_req,
    input  wire          i_brake_release,
    input  wire [15:0]   i_enc_ppr,
    input  wire          i_enc_ppr_wr,

    // Pins from the motor
    input  wire          i_enc_a,
    input  wire          i_enc_b,
    input  wire          i_commutation_track_u,
    input  wire          i_commutation_track_v,
    input  wire          i_commutation_track_w,
    input  wire          i_brake_overload,

    // Status outputs
    output reg  [`DFS_ERR_W-1:0] o_err_status,
    output reg  [`DFS_ST_W-1:0]  o_drive_state,
    output reg                   o_fault,
    output reg                   o_ps_uv_warn,
    output reg                   o_ready,
    output reg                   o_move_allow,
    output reg  [15:0]           o_enc_ppr,
    output reg                   o_brake_positive_output,
    output reg                   o_brake_negative_output
);

    // Reset resolution, cut to the register width on purpose
    localparam [15:0]  PPR_DEF   = PPR[15:0];
    // Shortest legal spacing of encoder edges, in clock cycles
    localparam integer ENC_MIN_I = `DFS_ENC_MIN_CYC;
    localparam [7:0]   ENC_MIN   = ENC_MIN_I[7:0];

    // Two-stage synchronisers for pin inputs: a, b, u, v, w, overload.
    // They run through reset, so the first sample after release is live
    // and no phantom sensor fault or encoder edge follows reset.
    reg [5:0] pin_s1_q;
    reg [5:0] pin_s2_q;
    always @(posedge i_clk) begin
        pin_s1_q <= {i_brake_overload, i_commutation_track_w, i_commutation_track_v,
                     i_commutation_track_u, i_enc_b, i_enc_a};
        pin_s2_q <= pin_s1_q;
    end

    // Previous synchronised samples for edge checks
    reg [4:0] pin_prev_q;
    reg [7:0] enc_gap_q;
    reg       sensor_bad;
    // A change on either quadrature track is one edge
    wire      enc_edge = (pin_s2_q[1:0] != pin_prev_q[1:0]);
    // Commutation code as w, v, u
    wire [2:0] hall = pin_s2_q[4:2];

    // Last sample, kept through reset like the synchronisers
    always @(posedge i_clk) begin
        pin_prev_q <= pin_s2_q[4:0];
    end

    // Cycles since the last encoder edge, saturating at all ones
    always @(posedge i_clk) begin
        if (i_rst) begin
            enc_gap_q <= 8'hFF;
        end else begin
            if (enc_edge)
                enc_gap_q <= 8'h00;
            else if (enc_gap_q != 8'hFF)
                enc_gap_q <= enc_gap_q + 8'h01;
        end
    end

    // Both quadrature tracks moving at once means a lost edge
    wire enc_jump = (pin_s2_q[0] != pin_prev_q[0]) && (pin_s2_q[1] != pin_prev_q[1]);
    // Edges closer than the top pulse rate point at noise, not motion
    wire enc_fast = enc_edge && (enc_gap_q < ENC_MIN - 8'h01);
    // Tracks 120 degrees apart never read all low or all high
    wire hall_bad = (hall == 3'h0) || (hall == 3'h7);

    // Sensor health: any of the three reasons above
    always @* begin
        sensor_bad = 1'b0;
        if (enc_jump)
            sensor_bad = 1'b1;                                      // see [R20]
        if (enc_fast)
            sensor_bad = 1'b1;                                      // see [R20]
        if (hall_bad)
            sensor_bad = 1'b1;                                      // see [R21]
    end

    // Encoder resolution register, software settable
    // Held for the position logic; nothing here scales by it
    always @(posedge i_clk) begin
        if (i_rst)
            o_enc_ppr <= PPR_DEF;                                   // see [R20]
        else if (i_enc_ppr_wr)
            o_enc_ppr <= i_enc_ppr;                                 // see [R20]
    end

    // The timer compare is strict, so a qualification time of N
    // reports on the hot edge after the counter has passed N.
    // Temperature qualification timers
    reg [TW-1:0] drv_tmr_q;
    reg [TW-1:0] mot_tmr_q;
    // Raw over-limit conditions, before qualification
    wire drv_hot = i_drv_temp > i_drv_temp_max;                     // see [R10]
    wire mot_hot = i_mot_temp > i_mot_temp_max;                     // see [R10]
    // A disabled timer reports at once; an enabled one waits
    wire drv_ot  = drv_hot && (!i_tmr_en_drv || drv_tmr_q > i_drv_temp_time); // see [R11]
    wire mot_ot  = mot_hot && (!i_tmr_en_mot || mot_tmr_q > i_mot_temp_time); // see [R11]
    always @(posedge i_clk) begin
        if (i_rst) begin
            drv_tmr_q <= {TW{1'b0}};                                // see [R23]
            mot_tmr_q <= {TW{1'b0}};
        end else begin
            // Saturate rather than wrap so a long overheat stays reported
            if (!drv_hot)
                drv_tmr_q <= {TW{1'b0}};
            else if (drv_tmr_q != {TW{1'b1}})
                drv_tmr_q <= drv_tmr_q + {{(TW-1){1'b0}}, 1'b1};   // see [R11]

            // Motor sensor, same scheme; restarts keep spikes from adding up
            if (!mot_hot)
                mot_tmr_q <= {TW{1'b0}};
            else if (mot_tmr_q != {TW{1'b1}})
                mot_tmr_q <= mot_tmr_q + {{(TW-1){1'b0}}, 1'b1};   // see [R11]
        end
    end

    // Limitations: measurements are compared as unsigned codes with no
    // hysteresis, so a value sitting on a limit can chatter; the latch
    // hides that chatter from the state machine.
    // Event strobes are level sensitive: a held strobe keeps its
    // error alive and blocks the reset until it drops.
    // Live error causes
    reg [`DFS_ERR_W-1:0] cause;
    always @* begin
        cause = {`DFS_ERR_W{1'b0}};
        // Supplies, current and following error
        cause[`DFS_E_LOGIC_UV] = i_logic_v < i_logic_v_min;         // see [R1]
        cause[`DFS_E_OVERCUR]  = i_out_cur > i_cur_max;             // see [R2]
        cause[`DFS_E_CSQT]     = i_rms_cur > i_csqt_max;            // see [R3]
        cause[`DFS_E_FOLLOW]   = i_follow_err > i_follow_max;       // see [R4]
        // Events reported by firmware side logic
        cause[`DFS_E_PARMEM]   = i_parmem_fail;                     // see [R5]
        cause[`DFS_E_BUS]      = i_bus_fail;                        // see [R6]
        cause[`DFS_E_PROC]     = i_proc_fail;                       // see [R7]
        // Power stage window
        cause[`DFS_E_PS_OV]    = i_ps_v > i_ps_v_max;               // see [R8]
        cause[`DFS_E_PS_UV]    = i_ps_v < i_ps_v_min;               // see [R9]
        // Qualified temperatures
        cause[`DFS_E_DRV_OT]   = drv_ot;                            // see [R10]
        cause[`DFS_E_MOT_OT]   = mot_ot;                            // see [R10]
        // Short circuit sense is meaningless on a collapsed supply
        cause[`DFS_E_SHORT]    = i_short_det &&
                                 (i_ps_v >= `DFS_SC_MIN_CODE);      // see [R19]
        cause[`DFS_E_SENSOR]   = sensor_bad;
    end

    // Masked errors still latch but do not count as faults;
    // only the two maskable bits ever carry a mask
    reg [`DFS_ERR_W-1:0] mask_vec;
    always @* begin
        mask_vec = {`DFS_ERR_W{1'b0}};
        mask_vec[`DFS_E_FOLLOW] = i_mask_follow;                    // see [R23]
        mask_vec[`DFS_E_PS_UV]  = i_mask_ps_uv;                     // see [R23]
    end

    // Sticky latches, one term per error bit
    wire [`DFS_ERR_W-1:0] err_d;
    genvar gi;
    generate
        for (gi = 0; gi < `DFS_ERR_W; gi = gi + 1) begin : g_latch
            // A live cause wins over a reset request
            assign err_d[gi] = cause[gi] ||
                               (o_err_status[gi] && !(i_err_reset && !cause[gi])); // see [R14]
        end
    endgenerate
    wire any_unmasked = |(err_d & ~mask_vec);                       // see [R24]
    always @(posedge i_clk) begin
        if (i_rst) begin
            o_err_status <= {`DFS_ERR_W{1'b0}};                     // see [R23]
            o_fault      <= 1'b0;
            o_ps_uv_warn <= 1'b0;
        end else begin
            o_err_status <= err_d;                                  // see [R13]
            o_fault      <= any_unmasked;                           // see [R24]
            // Warning only while masked; the latched bit still shows
            o_ps_uv_warn <= err_d[`DFS_E_PS_UV] & i_mask_ps_uv;     // see [R18]
        end
    end

    // The state machine reacts to the same-cycle error vector, so the
    // fault indication and the fault reaction state appear together.
    // Fault reaction lasts exactly one cycle here; a slower stop ramp
    // would sit outside this block.
    // Drive state machine
    localparam [3:0] ST_SOD   = `DFS_ST_SOD;
    localparam [3:0] ST_RUN   = `DFS_ST_RUN;
    localparam [3:0] ST_FRA   = `DFS_ST_FRA;
    localparam [3:0] ST_FAULT = `DFS_ST_FAULT;

    reg [3:0] st_d;
    always @* begin
        st_d = o_drive_state;
        case (o_drive_state)
            // Switch on disabled: wait for an enable request
            ST_SOD: begin
                if (any_unmasked)
                    st_d = ST_FRA;                                  // see [R12]
                else if (i_enable_req)
                    st_d = ST_RUN;
            end
            // Run: drop back when the request goes away
            ST_RUN: begin
                if (any_unmasked)
                    st_d = ST_FRA;                                  // see [R12]
                else if (!i_enable_req)
                    st_d = ST_SOD;
            end
            // Fault reaction: a single pass-through cycle
            ST_FRA: begin
                st_d = ST_FAULT;                                    // see [R12]
            end
            // Fault: wait for a reset that finds every unmasked cause gone
            ST_FAULT: begin
                // Leave only when the reset really emptied the unmasked set
                if (i_err_reset && !any_unmasked)
                    st_d = ST_SOD;                                  // see [R15]
            end
            // Any illegal code falls back to the safe state
            default: begin
                st_d = ST_SOD;
            end
        endcase
    end

    always @(posedge i_clk) begin
        if (i_rst) begin
            o_drive_state <= ST_SOD;
            o_ready       <= 1'b0;
            o_move_allow  <= 1'b0;
        end else begin
            // Flags follow the next state so they line up with it
            o_drive_state <= st_d;
            // Masked power undervoltage does not block readiness
            o_ready       <= (st_d == ST_SOD) || (st_d == ST_RUN);  // see [R18]
            o_move_allow  <= (st_d == ST_RUN);                      // see [R17]
        end
    end

    // The trip is taken from the synchronised pin only, so a glitch
    // shorter than a clock can be missed; the switch's own protection
    // covers that case.
    // Brake switch: energised releases the shaft, overload trips it off
    reg brk_trip_q;
    always @(posedge i_clk) begin
        if (i_rst) begin
            brk_trip_q              <= 1'b0;
            o_brake_positive_output <= 1'b0;
            o_brake_negative_output <= 1'b0;
        end else begin
            // Overload trip holds until an error reset; set wins over clear
            if (pin_s2_q[5])
                brk_trip_q <= 1'b1;                                 // see [R22]
            else if (i_err_reset)
                brk_trip_q <= 1'b0;
            o_brake_positive_output <= i_brake_release && !brk_trip_q &&
                                       !pin_s2_q[5] && (st_d == ST_RUN); // see [R22]
            // Return pole stays low; the switch acts on the positive side
            o_brake_negative_output <= 1'b0;
        end
    end

endmodule // dfs_supervisor
`default_nettype wire

// [tb/dfs_fb_master.sv]
`timescale 1ns/1ps
`default_nettype none
module dfs_fb_master (
    // Clock and observed status
    input  wire logic i_clk,
    input  wire logic i_go,
    input  wire logic i_ready,
    // Reset request and outcome
    output var logic  o_err_reset,
    output var logic  o_done,
    output var logic  o_ok
);
    int n;
    // Cause is gone when asked; pulse reset, then poll ready a few cycles
    initial begin
        o_err_reset = 1'h0;
        o_done = 1'h1;
        o_ok = 1'h0;
        forever begin
            @(posedge i_clk);
            if (i_go) begin
                o_done = 1'h0;
                @(negedge i_clk);
                o_err_reset = 1'h1;
                @(negedge i_clk);
                o_err_reset = 1'h0;
                o_ok = 1'h0;
                for (n = 0; n < 4 && !o_ok; n++) begin
                    @(negedge i_clk);
                    o_ok = i_ready;
                end
                o_done = 1'h1;
            end
        end
    end
endmodule // dfs_fb_master
`default_nettype wire

// [tb/dfs_supervisor_chk.sv]
`timescale 1ns/1ps
`default_nettype none
`include "dfs_map.vh"
module dfs_supervisor_chk (
    // Clock and reset
    input wire logic        i_clk,
    input wire logic        i_rst,
    // Causes and controls
    input wire logic [15:0] i_out_cur,
    input wire logic [15:0] i_cur_max,
    input wire logic [15:0] i_follow_err,
    input wire logic [15:0] i_follow_max,
    input wire logic [15:0] i_ps_v,
    input wire logic [15:0] i_ps_v_min,
    input wire logic        i_mask_follow,
    input wire logic        i_mask_ps_uv,
    input wire logic        i_err_reset,
    // Status
    input wire logic [12:0] o_err_status,
    input wire logic [3:0]  o_drive_state,
    input wire logic        o_fault,
    input wire logic        o_ps_uv_warn,
    input wire logic        o_ready
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);

    // Causes latch one edge later; a held latch only drops on reset
    overcur_latch_a: assert property (
        (i_out_cur > i_cur_max) |=> o_err_status[1]) else $error("overcurrent not latched");
    latch_hold_a: assert property (
        o_err_status[1] && !i_err_reset |=> o_err_status[1]) else $error("latch lost");
    reset_clear_a: assert property (
        o_err_status[1] && i_err_reset && !(i_out_cur > i_cur_max) |=> !o_err_status[1])
        else $error("reset did not clear");
    // State walk through fault reaction and back
    fault_entry_a: assert property (
        $rose(o_fault) |-> o_drive_state == `DFS_ST_FRA) else $error("fault without reaction");
    fra_exit_a: assert property (
        o_drive_state == `DFS_ST_FRA |=> o_drive_state == `DFS_ST_FAULT)
        else $error("reaction did not end in fault");
    fault_exit_a: assert property (
        o_drive_state == `DFS_ST_FAULT ##1 o_drive_state != `DFS_ST_FAULT
        |-> o_drive_state == `DFS_ST_SOD) else $error("fault left to wrong state");
    // Masks decide whether a cause becomes a fault
    follow_fault_a: assert property (
        (i_follow_err > i_follow_max) && !i_mask_follow |=> o_fault) else $error("no follow fault");
    masked_quiet_a: assert property (
        (o_err_status & ~13'h0108) == 13'h0000 && i_mask_follow && i_mask_ps_uv |-> !o_fault)
        else $error("masked error faulted");
    uv_warn_a: assert property (
        (i_ps_v < i_ps_v_min) && i_mask_ps_uv |=> o_ps_uv_warn) else $error("no warning");
    // Ready is skipped for two edges so reset values do not count
    ready_state_a: assert property (
        !$past(i_rst) && !$past(i_rst, 2) |-> o_ready ==
        (o_drive_state == `DFS_ST_SOD || o_drive_state == `DFS_ST_RUN)) else $error("bad ready");
    short_floor_a: assert property (
        i_ps_v < `DFS_SC_MIN_CODE && !o_err_status[11] |=> !o_err_status[11])
        else $error("short seen at low voltage");
    cover property (o_drive_state == `DFS_ST_FAULT ##1 o_drive_state == `DFS_ST_SOD);
    cover property (o_ps_uv_warn && !o_fault);
    cover property (i_err_reset && o_err_status[1]);
endmodule // dfs_supervisor_chk
bind dfs_supervisor dfs_supervisor_chk u_chk (.*);
`default_nettype wire

// [tb/dfs_supervisor_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "dfs_map.vh"
module dfs_supervisor_tb;
    // Block ports by their own names, plus master handshake
    logic        i_clk, i_rst, go, done, ok;
    logic [15:0] i_logic_v, i_out_cur, i_rms_cur, i_follow_err, i_ps_v, i_drv_temp, i_mot_temp;
    logic [15:0] i_logic_v_min, i_cur_max, i_csqt_max, i_follow_max, i_ps_v_max, i_ps_v_min;
    logic [15:0] i_drv_temp_max, i_mot_temp_max, i_drv_temp_time, i_mot_temp_time, i_enc_ppr;
    logic        i_mask_follow, i_mask_ps_uv, i_tmr_en_drv, i_tmr_en_mot, i_parmem_fail;
    logic        i_bus_fail, i_proc_fail, i_short_det, i_err_reset, i_enable_req, i_enc_ppr_wr;
    logic        i_brake_release, i_enc_a, i_enc_b, i_brake_overload, i_commutation_track_u;
    logic        i_commutation_track_v, i_commutation_track_w, o_fault, o_ps_uv_warn, o_ready;
    logic        o_move_allow, o_brake_positive_output, o_brake_negative_output;
    logic [12:0] o_err_status;
    logic [3:0]  o_drive_state;
    logic [15:0] o_enc_ppr;
    int          miscompares = 0, checked = 0, k;
    dfs_supervisor u_dut (.*);
    dfs_fb_master u_master (.i_clk(i_clk), .i_go(go), .i_ready(o_ready),
                            .o_err_reset(i_err_reset), .o_done(done), .o_ok(ok));
    // 100 ns clock
    initial begin
        i_clk = 1'h0;
        forever #50 i_clk = ~i_clk;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge i_clk);
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Hand the reset to the master; bounded wait for its verdict
    task automatic fb_reset;
        go = 1'h1;
        tick(1);
        go = 1'h0;
        for (int n = 0; n < 20 && !done; n++) tick(1);
    endtask
    // Each index drives one cause, numbered as its status bit
    task automatic cause(input int c, input logic on);
        case (c)
            0: i_logic_v = on ? 16'h0064 : 16'h00F0;
            1: i_out_cur = on ? 16'h0200 : 16'h0010;
            2: i_rms_cur = on ? 16'h0200 : 16'h0010;
            3: i_follow_err = on ? 16'h0200 : 16'h0010;
            4: i_parmem_fail = on;
            5: i_bus_fail = on;
            6: i_proc_fail = on;
            7: i_ps_v = on ? 16'h0400 : 16'h0200;
            default: i_ps_v = on ? 16'h0080 : 16'h0200;
        endcase
    endtask
    task automatic t_table;
        for (k = 0; k < 9; k++) begin
            cause(k, 1'h1);
            tick(1);
            cause(k, 1'h0);
            chk("latch", 16'h0001 << k, o_err_status);
            chk("react", `DFS_ST_FRA, o_drive_state);
            tick(1);
            chk("fault", `DFS_ST_FAULT, o_drive_state);
            fb_reset;
            chk("clear", 16'h0011, {ok, o_drive_state | {3'h0, |o_err_status}});
        end
        $display("test error table done");
    endtask
    // Reset while the cause stands must be refused
    task automatic t_refuse;
        cause(1, 1'h1);
        tick(2);
        fb_reset;
        chk("kept", 16'h0011, {ok, o_drive_state, o_err_status[1]});
        cause(1, 1'h0);
        fb_reset;
        chk("freed", 16'h0022, {ok, o_drive_state, o_err_status[1]});
        $display("test refused reset done");
    endtask
    // Just below and at the short-circuit voltage floor
    task automatic t_short;
        i_ps_v_min = 16'h0010;
        for (k = 0; k < 2; k++) begin
            i_ps_v = 16'h0063 + k[15:0];
            i_short_det = 1'h1;
            tick(1);
            i_short_det = 1'h0;
            chk("short", k[0] ? 16'h0800 : 16'h0000, o_err_status);
            tick(1);
            fb_reset;
        end
        {i_ps_v, i_ps_v_min} = {16'h0200, 16'h0100};
        $display("test short floor done");
    endtask
    // A commutation code no 120-degree sensor gives latches the sensor error
    task automatic t_sensor;
        i_commutation_track_u = 1'h0;
        tick(4);
        chk("sensor", 16'h1000, o_err_status);
        i_commutation_track_u = 1'h1;
        tick(3);
        fb_reset;
        chk("sensor clear", 16'h0002, {o_drive_state, |o_err_status});
        $display("test sensor done");
    endtask
    // Brief heat is forgiven, long heat latches, per sensor
    task automatic t_temp;
        for (k = 0; k < 2; k++) begin
            {i_mot_temp, i_drv_temp} = k ? 32'h0060_0020 : 32'h0020_0060;
            tick(6);
            {i_mot_temp, i_drv_temp} = 32'h0020_0020;
            tick(1);
            chk("brief", 16'h0000, o_err_status);
            {i_mot_temp, i_drv_temp} = k ? 32'h0060_0020 : 32'h0020_0060;
            tick(12);
            {i_mot_temp, i_drv_temp} = 32'h0020_0020;
            chk("hot", 16'h0200 << k, o_err_status);
            fb_reset;
        end
        $display("test temperature done");
    endtask
    // Masked errors in run, then brake and resolution
    task automatic t_run;
        i_enable_req = 1'h1;
        tick(2);
        {i_mask_follow, i_mask_ps_uv} = 2'h3;
        cause(3, 1'h1);
        cause(8, 1'h1);
        tick(2);
        chk("masked", 16'h0108, o_err_status);
        chk("flags", 16'h0007, {o_fault, o_ps_uv_warn, o_ready, o_move_allow});
        cause(3, 1'h0);
        cause(8, 1'h0);
        fb_reset;
        {i_mask_follow, i_mask_ps_uv, i_brake_release} = 3'h1;
        tick(2);
        chk("brake", 16'h0002, {o_brake_positive_output, o_brake_negative_output});
        i_brake_overload = 1'h1;
        tick(4);
        chk("trip", 16'h0000, {o_brake_positive_output, o_brake_negative_output});
        {i_brake_overload, i_enc_ppr, i_enc_ppr_wr} = {1'h0, 16'h0400, 1'h1};
        tick(1);
        i_enc_ppr_wr = 1'h0;
        chk("ppr", 16'h0400, o_enc_ppr);
        $display("test run, brake and encoder done");
    endtask
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Main sequence; limits stay fixed except i_ps_v_min in t_short, measurements move
    initial begin
        {go, i_mask_follow, i_mask_ps_uv, i_parmem_fail, i_bus_fail, i_proc_fail} = '0;
        {i_short_det, i_enable_req, i_brake_release, i_enc_ppr_wr, i_brake_overload} = '0;
        {i_enc_a, i_enc_b, i_commutation_track_u, i_commutation_track_v} = 4'h2;
        {i_commutation_track_w, i_tmr_en_drv, i_tmr_en_mot, i_rst} = 4'h7;
        {i_logic_v_min, i_cur_max, i_csqt_max, i_follow_max} = {16'h00C8, {3{16'h0100}}};
        {i_ps_v_max, i_ps_v_min, i_drv_temp_max, i_mot_temp_max} = {16'h0300, 16'h0100, {2{16'h0050}}};
        {i_drv_temp_time, i_mot_temp_time} = {2{16'h0008}};
        {i_drv_temp, i_mot_temp, i_enc_ppr} = {{2{16'h0020}}, 16'h0000};
        for (k = 0; k < 9; k++) cause(k, 1'h0);
        tick(16);
        i_rst = 1'h0;
        tick(3);
        chk("reset", 16'h0003, {o_fault, o_brake_positive_output, o_drive_state, o_ready});
        chk("err", 16'h0000, o_err_status);
        chk("ppr", 16'h0800, o_enc_ppr);
        $display("test reset done");
        t_table;
        t_refuse;
        t_short;
        t_sensor;
        t_temp;
        t_run;
        complete_run;
    end
    // Watchdog, well beyond the few hundred cycles the tests need
    initial begin
        repeat (4000) @(posedge i_clk);
        miscompares++;
        complete_run;
    end
endmodule // dfs_supervisor_tb
`default_nettype wire
